// File: bench/tcw_pin_load.sv
`timescale 1ns/1ps
module tcw_pin_load #(
	parameter int unsigned NCH = 2
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [NCH-1:0] pin,
	output logic [15:0] rise_r
);
	logic last_r;
	// The pin is only a load, but counting the rising edges of pin[0] exposes glitches that spot checks miss.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			last_r <= 1'b0;
			rise_r <= 16'h0000;
		end
		else
		begin
			last_r <= pin[0];
			if (pin[0] && !last_r)
				rise_r <= rise_r + 16'h0001;
		end
	end
endmodule

// File: bench/test_timer_compare_output_waveform.sv
`timescale 1ns/1ps
module test_timer_compare_output_waveform;
	localparam int unsigned NCH = 2;
	logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, slv;
	logic pol, prev, pr, dn, m0, m1, p, q, w1;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [NCH-1:0] capture_trig, match_out, channel_wave_out, st;
	logic [15:0] rise_r, lfsr, d0, d1, idle, v, exp_rise;
	logic [2:0] g;
	logic [1:0] k;
	tcw_pkg::tcw_cnt_type cnt_in;
	int err_total, check_count;

	tcw_top #(.NCH(NCH)) tcw_top_i (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cnt_in(cnt_in), .capture_trig(capture_trig), .match_out(match_out), .channel_wave_out(channel_wave_out));
	tcw_pin_load #(.NCH(NCH)) tcw_pin_load_i (.pclk(pclk), .presetn(presetn), .pin(channel_wave_out), .rise_r(rise_r));

	initial
	begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	function logic [15:0] rnd();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr;
	endfunction

	function logic [31:0] ctlw(input logic pa, input logic lv, input logic [2:0] gm, input logic pl, input logic md);
		return {25'h0000000, pa, lv, gm, pl, md};
	endfunction

	// A period event wins over the own match, so it is tested first.
	function logic nxt(input logic [2:0] gm, input logic s, input logic m, input logic pe);
		case (gm)
			3'h1: return s | m;
			3'h2: return pe ? 1'b0 : s ^ m;
			3'h3: return pe ? 1'b0 : s | m;
			3'h4: return s ^ m;
			3'h5: return s & ~m;
			3'h6: return pe ? 1'b1 : s ^ m;
			3'h7: return pe ? 1'b1 : s & ~m;
			default: return s;
		endcase
	endfunction

	task chk(input logic [31:0] seen, input logic [31:0] expv);
		check_count++;
		if (seen !== expv)
		begin
			err_total++;
			$display("Error at %0t: seen %h expected %h", $time, seen, expv);
		end
	endtask

	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task ev(input logic [15:0] val, input logic mx, input logic zr, input logic down, input logic cap);
		cnt_in <= '{val, 1'b1, mx, zr, down};
		capture_trig <= {cap, cap};
		@(posedge pclk);
		cnt_in <= '{idle, 1'b0, 1'b0, 1'b0, down};
		capture_trig <= '0;
		@(posedge pclk);
	endtask

	task stop_test;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial
	begin
		repeat (5000) @(posedge pclk);
		err_total++;
		stop_test;
	end

	initial
	begin
		lfsr = 16'h18C9;
		presetn = 1'b0;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		cnt_in = '0;
		capture_trig = '0;
		err_total = 0;
		check_count = 0;
		st = '0;
		prev = 1'b0;
		exp_rise = 16'h0000;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, 12'h000, 32'h00000000);
		chk(rd, 32'h00000000);
		apb(1'b0, 12'h004, 32'h00000000);
		chk(rd, 32'h00000000);
		d0 = rnd() | 16'h0002;
		d1 = d0 ^ 16'h8000;
		idle = d0 ^ 16'h0001;
		apb(1'b1, 12'h004, {16'h0000, d0});
		apb(1'b1, 12'h00C, {16'h0000, d1});
		apb(1'b0, 12'h00C, 32'h00000000);
		chk(rd, {16'h0000, d1});
		apb(1'b0, 12'h0F0, 32'h00000000);
		chk(32'(slv), 32'h00000001);
		chk(rd, 32'h00000000);
		$display("test reset and data done");
		for (int i = 0; i < 60; i++)
		begin
			g = 3'(rnd() % 16'h0007) + 3'h1;
			pr = lfsr[3];
			dn = lfsr[5];
			pol = lfsr[7];
			k = 2'(rnd());
			apb(1'b1, 12'h000, ctlw(pr, 1'b0, g, pol, 1'b0));
			apb(1'b1, 12'h008, ctlw(pr, 1'b0, g, pol, 1'b0));
			w1 = st[0] ^ pol;
			v = (k == 2'h0) ? d0 : (k == 2'h1) ? d1 : idle;
			ev(v, k == 2'h2, k == 2'h3, dn, 1'b0);
			chk(32'(match_out), {30'h0, k == 2'h1, k == 2'h0});
			m0 = k == 2'h0;
			m1 = k == 2'h1;
			p = dn ? k == 2'h3 : k == 2'h2;
			q = g == 3'h1 || g == 3'h4 || g == 3'h5;
			st[0] = nxt(g, st[0], pr && q ? m0 | m1 : m0, pr ? m1 : p);
			st[1] = nxt(g, st[1], pr && q ? m0 | m1 : m1, pr ? m0 : p);
			exp_rise = exp_rise + 16'(!prev && w1) + 16'(!w1 && (st[0] ^ pol));
			prev = st[0] ^ pol;
			repeat (2) @(posedge pclk);
			chk(32'(channel_wave_out), 32'(st ^ {pol, pol}));
		end
		chk(32'(rise_r), 32'(exp_rise));
		apb(1'b0, 12'h100, 32'h00000000);
		chk(rd, 32'({st, st ^ {pol, pol}}));
		apb(1'b1, 12'h100, 32'h00000000);
		chk(32'(slv), 32'h00000001);
		ce <= 1'b0;
		ev(d0, 1'b1, 1'b1, 1'b0, 1'b0);
		chk(32'(match_out), 32'h00000000);
		chk(32'(channel_wave_out), 32'(st ^ {pol, pol}));
		ce <= 1'b1;
		$display("test generation modes done");
		for (int j = 0; j < 4; j++)
		begin
			apb(1'b1, 12'h000, ctlw(1'b0, j[1], 3'h0, j[0], 1'b0));
			repeat (2) @(posedge pclk);
			chk(32'(channel_wave_out[0]), 32'(j[1] ^ j[0]));
		end
		$display("test software level done");
		apb(1'b1, 12'h000, ctlw(1'b0, 1'b1, 3'h4, 1'b0, 1'b1));
		apb(1'b1, 12'h008, ctlw(1'b0, 1'b0, 3'h4, ~pol, 1'b1));
		v = rnd();
		ev(v, 1'b1, 1'b1, 1'b0, 1'b1);
		chk(32'(match_out), 32'h00000000);
		repeat (2) @(posedge pclk);
		chk(32'(channel_wave_out), 32'({st[1] ^ pol, 1'b0}));
		apb(1'b0, 12'h004, 32'h00000000);
		chk(rd, {16'h0000, v});
		apb(1'b0, 12'h00C, 32'h00000000);
		chk(rd, {16'h0000, v});
		$display("test capture done");
		stop_test;
	end
endmodule

// File: pkg/tcw_pkg.sv
// Overview of operation
// RULE1 - Software mode drives output from level bit.
// RULE2 - Level bit one means high, zero low.
// RULE3 - Output controls ignored while capture mode runs.
// RULE4 - Mode 7: match clears, period event sets.
// RULE5 - Mode 6: match toggles, period event sets.
// RULE6 - Mode 5: match makes output inactive.
// RULE7 - Mode 4: each match inverts output.
// RULE8 - Mode 3: match sets, period event clears.
// RULE9 - Mode 2: match toggles, period event clears.
// RULE10 - Mode 1: match makes output active.
// RULE11 - Polarity one inverts output, zero passes.
// RULE12 - Mode bit one capture, zero compare.
// RULE13 - Data register holds compare value, resets zero.
// RULE14 - Capture loads counter value on trigger.
// RULE15 - Pairing uses partner match, else MAX/ZERO.
// RULE16 - Match strobe one cycle on equality.
// RULE17 - Polarity applied after the generation logic.
package tcw_pkg;

	localparam int unsigned CNT_W = 16;
	localparam int unsigned APB_AW = 12;
	localparam int unsigned APB_DW = 32;

	// Each channel owns an eight-byte window: control word, then data word.
	localparam logic [APB_AW-1:0] CH_STRIDE = 12'h008;
	localparam logic [APB_AW-1:0] CTL_OFS = 12'h000;
	localparam logic [APB_AW-1:0] DATA_OFS = 12'h004;
	localparam logic [APB_AW-1:0] STAT_OFS = 12'h100;

	localparam logic [2:0] GEN_SW = 3'h0;
	localparam logic [2:0] GEN_SET = 3'h1;
	localparam logic [2:0] GEN_TOG_RST = 3'h2;
	localparam logic [2:0] GEN_SET_RST = 3'h3;
	localparam logic [2:0] GEN_TOG = 3'h4;
	localparam logic [2:0] GEN_RST = 3'h5;
	localparam logic [2:0] GEN_TOG_SET = 3'h6;
	localparam logic [2:0] GEN_RST_SET = 3'h7;

	// Field order from bit 0 upward: mode, polarity, generation mode, level, pairing.
	typedef struct packed {
		logic pair_output_select;
		logic sw_output_level;
		logic [2:0] output_gen_mode;
		logic output_polarity;
		logic channel_mode_select;
	} tcw_ctl_type;

	localparam int unsigned CTL_W = 7;
	localparam tcw_ctl_type CTL_RST = 7'h00;
	localparam logic [CNT_W-1:0] DATA_RST = 16'h0000;

	typedef struct packed {
		logic [CNT_W-1:0] value;
		logic step;
		logic max;
		logic zero;
		logic down;
	} tcw_cnt_type;

endpackage

// File: rtl/tcw_cmp.sv
`timescale 1ns/1ps
module tcw_cmp (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic enable,
	input wire tcw_pkg::tcw_cnt_type cnt,
	input wire logic [tcw_pkg::CNT_W-1:0] cmp_value,
	output logic match_r
);

	// Qualifying with the counter step keeps a stalled counter from repeating the strobe.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			match_r <= 1'b0;
		else if (ce)
			match_r <= enable && cnt.step && (cnt.value == cmp_value); // RULE16
	end

	property p_match_cause;
		@(posedge pclk) disable iff (!presetn)
		(match_r && $past(ce)) |-> $past(enable && cnt.step && (cnt.value == cmp_value));
	endproperty
	a_match_cause: assert property (p_match_cause) else $error("match without equality"); // RULE16

	property p_match_pulse;
		@(posedge pclk) disable iff (!presetn)
		(ce && enable && cnt.step && (cnt.value == cmp_value)) |=> match_r;
	endproperty
	a_match_pulse: assert property (p_match_pulse) else $error("equality gave no match"); // RULE16

endmodule

// File: rtl/tcw_top.sv
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module tcw_top #(
	parameter int unsigned NCH = 2
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [tcw_pkg::APB_AW-1:0] paddr,
	input wire logic [tcw_pkg::APB_DW-1:0] pwdata,
	output logic [tcw_pkg::APB_DW-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire tcw_pkg::tcw_cnt_type cnt_in,
	input wire logic [NCH-1:0] capture_trig,
	output logic [NCH-1:0] match_out,
	output logic [NCH-1:0] channel_wave_out
);

	localparam int unsigned CH_W = (NCH > 1) ? $clog2(NCH) : 1;

	// The status word carries two bits per channel, so sixteen channels fill it.
	generate
		if (NCH < 2 || (NCH % 2) != 0 || NCH > 16)
		begin : g_bad_nch
			$error("NCH must be an even count from 2 to 16");
		end
	endgenerate

	tcw_pkg::tcw_ctl_type ctl_r [NCH];
	logic [tcw_pkg::CNT_W-1:0] data_r [NCH];
	logic [NCH-1:0] state_w;
	logic pready_r;
	logic pslverr_r;
	logic [tcw_pkg::APB_DW-1:0] prdata_r;
	logic hit;
	logic hit_stat;
	logic sel_data;
	logic [CH_W-1:0] sel_ch;
	logic [tcw_pkg::APB_DW-1:0] rd_word;
	logic access;
	logic wr_go;

	// Decode: each channel window holds a control word and a data word; one status word sits above.
	always_comb
	begin
		hit = 1'b0;
		hit_stat = 1'b0;
		sel_data = 1'b0;
		sel_ch = '0;
		if (paddr == tcw_pkg::STAT_OFS)
			hit_stat = 1'b1;
		else
		begin
			for (int i = 0; i < NCH; i++)
			begin
				if (paddr == tcw_pkg::APB_AW'(i * tcw_pkg::CH_STRIDE + tcw_pkg::CTL_OFS))
				begin
					hit = 1'b1;
					sel_ch = CH_W'(i);
					sel_data = 1'b0;
				end
				else if (paddr == tcw_pkg::APB_AW'(i * tcw_pkg::CH_STRIDE + tcw_pkg::DATA_OFS))
				begin
					hit = 1'b1;
					sel_ch = CH_W'(i);
					sel_data = 1'b1;
				end
			end
		end
	end

	always_comb
	begin
		rd_word = '0;
		if (hit_stat)
			rd_word = tcw_pkg::APB_DW'({state_w, channel_wave_out});
		else if (hit && sel_data)
			rd_word = tcw_pkg::APB_DW'(data_r[sel_ch]);
		else if (hit)
			rd_word = tcw_pkg::APB_DW'(ctl_r[sel_ch]);
	end

	// The first access cycle prepares the answer; the write lands with pready in the second.
	assign access = ce && psel && penable;
	assign wr_go = access && pready_r && pwrite && hit;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pready_r <= 1'b0;
		else if (ce)
			pready_r <= access && !pready_r;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pslverr_r <= 1'b0;
		else if (ce)
			pslverr_r <= access && !pready_r && !hit && !(hit_stat && !pwrite);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_r <= '0;
		else if (ce && access && !pready_r)
			prdata_r <= pwrite ? '0 : rd_word;
	end

	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign prdata = prdata_r;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < NCH; i++)
				ctl_r[i] <= tcw_pkg::CTL_RST;
		end
		else if (wr_go && !sel_data)
			ctl_r[sel_ch] <= tcw_pkg::tcw_ctl_type'(pwdata[tcw_pkg::CTL_W-1:0]); // RULE12
	end

	// A capture arriving with a software write wins, so the hardware event is kept.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < NCH; i++)
				data_r[i] <= tcw_pkg::DATA_RST; // RULE13
		end
		else
		begin
			for (int i = 0; i < NCH; i++)
			begin
				if (ce && ctl_r[i].channel_mode_select && capture_trig[i])
					data_r[i] <= cnt_in.value; // RULE14
				else if (wr_go && sel_data && sel_ch == CH_W'(i))
					data_r[i] <= pwdata[tcw_pkg::CNT_W-1:0]; // RULE13
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < NCH; g++)
		begin : g_ch
			tcw_cmp u_cmp (
				.pclk(pclk),
				.presetn(presetn),
				.ce(ce),
				.enable(!ctl_r[g].channel_mode_select), // RULE12
				.cnt(cnt_in),
				.cmp_value(data_r[g]), // RULE13
				.match_r(match_out[g])
			);

			// Partner of channel m is m xor 1, giving the pairs 0/1, 2/3, 4/5.
			tcw_wave u_wave (
				.pclk(pclk),
				.presetn(presetn),
				.ce(ce),
				.ctl(ctl_r[g]),
				.own_match(match_out[g]),
				.other_match(match_out[g ^ 1]), // RULE15
				.cnt(cnt_in),
				.state_r(state_w[g]),
				.wave_r(channel_wave_out[g])
			);
		end
	endgenerate

	property p_capture_load;
		@(posedge pclk) disable iff (!presetn)
		(ce && ctl_r[0].channel_mode_select && capture_trig[0]) |=> data_r[0] == $past(cnt_in.value);
	endproperty
	a_capture_load: assert property (p_capture_load) else $error("capture value not loaded"); // RULE14

	property p_data_write;
		@(posedge pclk) disable iff (!presetn)
		(wr_go && sel_data && sel_ch == '0 && !(ce && ctl_r[0].channel_mode_select && capture_trig[0]))
			|=> data_r[0] == $past(pwdata[tcw_pkg::CNT_W-1:0]);
	endproperty
	a_data_write: assert property (p_data_write) else $error("compare value not stored"); // RULE13

	property p_ctl_write;
		@(posedge pclk) disable iff (!presetn)
		(wr_go && !sel_data && sel_ch == '0)
			|=> ctl_r[0].channel_mode_select == $past(pwdata[0]);
	endproperty
	a_ctl_write: assert property (p_ctl_write) else $error("mode bit not stored"); // RULE12

	property p_capture_no_match;
		@(posedge pclk) disable iff (!presetn)
		(ce && ctl_r[1].channel_mode_select) |=> !match_out[1];
	endproperty
	a_capture_no_match: assert property (p_capture_no_match) else $error("match in capture mode"); // RULE12

	property p_ready_answer;
		@(posedge pclk) disable iff (!presetn)
		(access && !pready_r) |=> pready_r ##1 !pready_r;
	endproperty
	a_ready_answer: assert property (p_ready_answer) else $error("apb answer timing wrong");

	property p_pready_pulse;
		@(posedge pclk) disable iff (!presetn)
		(ce && pready_r) |=> !pready_r;
	endproperty
	a_pready_pulse: assert property (p_pready_pulse) else $error("pready stood too long");

	property p_ready_needs_access;
		@(posedge pclk) disable iff (!presetn)
		$rose(pready_r) |-> $past(access);
	endproperty
	a_ready_needs_access: assert property (p_ready_needs_access) else $error("pready without access");

	property p_err_unmapped;
		@(posedge pclk) disable iff (!presetn)
		(access && !pready_r && !hit && !hit_stat) |=> pslverr_r;
	endproperty
	a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access gave no error");

	property p_err_stat_write;
		@(posedge pclk) disable iff (!presetn)
		(access && !pready_r && hit_stat && pwrite) |=> pslverr_r;
	endproperty
	a_err_stat_write: assert property (p_err_stat_write) else $error("status write gave no error");

	property p_no_err_mapped;
		@(posedge pclk) disable iff (!presetn)
		(access && !pready_r && hit) |=> !pslverr_r;
	endproperty
	a_no_err_mapped: assert property (p_no_err_mapped) else $error("mapped access gave an error");

	property p_err_with_ready;
		@(posedge pclk) disable iff (!presetn)
		pslverr_r |-> pready_r;
	endproperty
	a_err_with_ready: assert property (p_err_with_ready) else $error("pslverr without pready");

	property p_stat_read;
		@(posedge pclk) disable iff (!presetn)
		(access && !pready_r && !pwrite && hit_stat)
			|=> prdata_r == tcw_pkg::APB_DW'($past({state_w, channel_wave_out}));
	endproperty
	a_stat_read: assert property (p_stat_read) else $error("status word read wrong");

	property p_read_zero_unmapped;
		@(posedge pclk) disable iff (!presetn)
		(access && !pready_r && !pwrite && !hit && !hit_stat) |=> prdata_r == '0;
	endproperty
	a_read_zero_unmapped: assert property (p_read_zero_unmapped) else $error("unmapped read not zero");

	property p_write_read_zero;
		@(posedge pclk) disable iff (!presetn)
		(access && !pready_r && pwrite) |=> prdata_r == '0;
	endproperty
	a_write_read_zero: assert property (p_write_read_zero) else $error("write left read data");

	property p_write_ignored;
		@(posedge pclk) disable iff (!presetn)
		(access && pready_r && pwrite && !hit && !(ctl_r[0].channel_mode_select && capture_trig[0]))
			|=> $stable(ctl_r[0]) && $stable(data_r[0]);
	endproperty
	a_write_ignored: assert property (p_write_ignored) else $error("refused write changed a register");

	property p_ce_freeze;
		@(posedge pclk) disable iff (!presetn)
		!ce |=> $stable(ctl_r[0]) && $stable(data_r[0]) && $stable(pready_r) && $stable(pslverr_r)
			&& $stable(match_out) && $stable(channel_wave_out);
	endproperty
	a_ce_freeze: assert property (p_ce_freeze) else $error("state moved with enable low");

	property p_ctl_fields;
		@(posedge pclk) disable iff (!presetn)
		(wr_go && !sel_data && sel_ch == '0)
			|=> ctl_r[0] == tcw_pkg::tcw_ctl_type'($past(pwdata[tcw_pkg::CTL_W-1:0]));
	endproperty
	a_ctl_fields: assert property (p_ctl_fields) else $error("control fields not stored");

	property p_ch1_data_write;
		@(posedge pclk) disable iff (!presetn)
		(wr_go && sel_data && sel_ch == CH_W'(1) && !(ce && ctl_r[1].channel_mode_select && capture_trig[1]))
			|=> data_r[1] == $past(pwdata[tcw_pkg::CNT_W-1:0]);
	endproperty
	a_ch1_data_write: assert property (p_ch1_data_write) else $error("second compare value not stored"); // RULE13

	property p_capture_load1;
		@(posedge pclk) disable iff (!presetn)
		(ce && ctl_r[1].channel_mode_select && capture_trig[1]) |=> data_r[1] == $past(cnt_in.value);
	endproperty
	a_capture_load1: assert property (p_capture_load1) else $error("second capture not loaded"); // RULE14

	property p_capture_no_match0;
		@(posedge pclk) disable iff (!presetn)
		(ce && ctl_r[0].channel_mode_select) |=> !match_out[0];
	endproperty
	a_capture_no_match0: assert property (p_capture_no_match0) else $error("first match in capture mode"); // RULE12

	c_capture: cover property (@(posedge pclk) disable iff (!presetn)
		ctl_r[0].channel_mode_select && capture_trig[0] && ce);
	c_read_data: cover property (@(posedge pclk) disable iff (!presetn)
		access && pready_r && !pwrite && hit && sel_data);

endmodule

// File: rtl/tcw_wave.sv
`timescale 1ns/1ps
module tcw_wave (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire tcw_pkg::tcw_ctl_type ctl,
	input wire logic own_match,
	input wire logic other_match,
	input wire tcw_pkg::tcw_cnt_type cnt,
	output logic state_r,
	output logic wave_r
);

	logic ev_a;
	logic ev_b;
	logic state_nxt;

	always_comb
	begin
		ev_a = own_match;
		ev_b = ctl.pair_output_select ? other_match : (cnt.down ? cnt.zero : cnt.max); // RULE15
		state_nxt = state_r;
		if (!ctl.channel_mode_select)
		begin
			// When both events coincide the period event wins, so the cycle start is never lost.
			case (ctl.output_gen_mode)
				tcw_pkg::GEN_SW: state_nxt = ctl.sw_output_level; // RULE1 RULE2
				tcw_pkg::GEN_SET: if (ev_a || (ctl.pair_output_select && other_match)) state_nxt = 1'b1; // RULE10
				tcw_pkg::GEN_TOG_RST: if (ev_b) state_nxt = 1'b0; else if (ev_a) state_nxt = ~state_r; // RULE9
				tcw_pkg::GEN_SET_RST: if (ev_b) state_nxt = 1'b0; else if (ev_a) state_nxt = 1'b1; // RULE8
				tcw_pkg::GEN_TOG: if (ev_a || (ctl.pair_output_select && other_match)) state_nxt = ~state_r; // RULE7
				tcw_pkg::GEN_RST: if (ev_a || (ctl.pair_output_select && other_match)) state_nxt = 1'b0; // RULE6
				tcw_pkg::GEN_TOG_SET: if (ev_b) state_nxt = 1'b1; else if (ev_a) state_nxt = ~state_r; // RULE5
				default: if (ev_b) state_nxt = 1'b1; else if (ev_a) state_nxt = 1'b0; // RULE4
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state_r <= 1'b0;
		else if (ce)
			state_r <= state_nxt;
	end

	// In capture mode the pin simply holds, so polarity writes cannot glitch it.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			wave_r <= 1'b0;
		else if (ce && !ctl.channel_mode_select) // RULE3
			wave_r <= state_nxt ^ ctl.output_polarity; // RULE11 RULE17
	end

	property p_sw_level;
		@(posedge pclk) disable iff (!presetn)
		(ce && !ctl.channel_mode_select && ctl.output_gen_mode == tcw_pkg::GEN_SW)
			|=> wave_r == ($past(ctl.sw_output_level) ^ $past(ctl.output_polarity));
	endproperty
	a_sw_level: assert property (p_sw_level) else $error("software level not shown"); // RULE1

	property p_capture_hold;
		@(posedge pclk) disable iff (!presetn)
		ctl.channel_mode_select |=> $stable(wave_r) && $stable(state_r);
	endproperty
	a_capture_hold: assert property (p_capture_hold) else $error("output moved in capture mode"); // RULE3

	property p_polarity_after;
		@(posedge pclk) disable iff (!presetn)
		(ce && !ctl.channel_mode_select) |=> wave_r == (state_r ^ $past(ctl.output_polarity));
	endproperty
	a_polarity_after: assert property (p_polarity_after) else $error("polarity not applied last"); // RULE17

	property p_rst_set;
		@(posedge pclk) disable iff (!presetn)
		(ce && !ctl.channel_mode_select && ctl.output_gen_mode == tcw_pkg::GEN_RST_SET && !ctl.pair_output_select
			&& !cnt.down && cnt.max) |=> state_r;
	endproperty
	a_rst_set: assert property (p_rst_set) else $error("max did not set output"); // RULE4

	property p_set_rst;
		@(posedge pclk) disable iff (!presetn)
		(ce && !ctl.channel_mode_select && ctl.output_gen_mode == tcw_pkg::GEN_SET_RST && own_match && !ev_b)
			|=> state_r;
	endproperty
	a_set_rst: assert property (p_set_rst) else $error("match did not set output"); // RULE8

	property p_toggle;
		@(posedge pclk) disable iff (!presetn)
		(ce && !ctl.channel_mode_select && ctl.output_gen_mode == tcw_pkg::GEN_TOG && own_match)
			|=> state_r != $past(state_r);
	endproperty
	a_toggle: assert property (p_toggle) else $error("toggle missed"); // RULE7

	property p_reset_pair;
		@(posedge pclk) disable iff (!presetn)
		(ce && !ctl.channel_mode_select && ctl.output_gen_mode == tcw_pkg::GEN_RST && ctl.pair_output_select
			&& other_match) |=> !state_r;
	endproperty
	a_reset_pair: assert property (p_reset_pair) else $error("pair match did not reset"); // RULE6

	property p_set_mode;
		@(posedge pclk) disable iff (!presetn)
		(ce && !ctl.channel_mode_select && ctl.output_gen_mode == tcw_pkg::GEN_SET && own_match) |=> state_r;
	endproperty
	a_set_mode: assert property (p_set_mode) else $error("set mode missed"); // RULE10

	property p_tog_set_zero;
		@(posedge pclk) disable iff (!presetn)
		(ce && !ctl.channel_mode_select && ctl.output_gen_mode == tcw_pkg::GEN_TOG_SET && !ctl.pair_output_select
			&& cnt.down && cnt.zero) |=> state_r;
	endproperty
	a_tog_set_zero: assert property (p_tog_set_zero) else $error("zero did not set output"); // RULE5

	property p_tog_rst_pair;
		@(posedge pclk) disable iff (!presetn)
		(ce && !ctl.channel_mode_select && ctl.output_gen_mode == tcw_pkg::GEN_TOG_RST && ctl.pair_output_select
			&& other_match) |=> !state_r;
	endproperty
	a_tog_rst_pair: assert property (p_tog_rst_pair) else $error("pair match did not clear"); // RULE9

	c_toggle_run: cover property (@(posedge pclk) disable iff (!presetn)
		(ctl.output_gen_mode == tcw_pkg::GEN_TOG && own_match) ##[1:50] own_match);
	c_pair_pwm: cover property (@(posedge pclk) disable iff (!presetn)
		(ctl.pair_output_select && ctl.output_gen_mode == tcw_pkg::GEN_RST_SET && other_match) ##[1:50] own_match);

endmodule
